// ---- hdl/sea_defs.vh ----
`ifndef SEA_DEFS_VH
`define SEA_DEFS_VH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define SEA_ADR_CTRL 8'h00
`define SEA_ADR_STAT 8'h04
`define SEA_CTRL_EN_BIT 0
`define SEA_CTRL_EN_RST 1'h1
`define SEA_STAT_BUSY_BIT 0
`define SEA_STAT_PAGE_BIT 1
`define SEA_STAT_ROW_LSB 4

// ----------------------------------------
// Control byte layout and codes
// ----------------------------------------
`define SEA_CB_ROW_MSB 7
`define SEA_CB_ROW_LSB 3
`define SEA_CB_MODE_MSB 2
`define SEA_CB_MODE_LSB 1
`define SEA_CB_DIR_BIT 0
`define SEA_MODE_LOW_INC 2'h1
`define SEA_MODE_HIGH_DEC 2'h2
`define SEA_CMD_PAGE1 8'h01
`define SEA_CMD_PAGE0 8'h09
`define SEA_CMD_FILL0 8'h07
`define SEA_CMD_FILL1 8'h0F
`define SEA_CMD_INIT 8'hFF
`define SEA_PAGE_RST 1'h0

// ----------------------------------------
// Array shape
// ----------------------------------------
`define SEA_ROW_W 5
`define SEA_WORD_W 16
`define SEA_ADDR_W 6

// ----------------------------------------
// Timing
// ----------------------------------------
`define SEA_CLK_MHZ 25
`define SEA_PROG_TIME_US 10000
`define SEA_PROG_CYCLES (`SEA_PROG_TIME_US * `SEA_CLK_MHZ)

`endif

// ---- hdl/sea_mem.v ----
`timescale 1ns/1ps

// ----------------------------------------
// Word array, one write port, registered read port
// ----------------------------------------
module sea_mem #(
  parameter integer AW = 6,
  parameter integer DW = 16
)(
  input wire clk_i,
  input wire we_i,
  input wire [AW-1:0] wa_i,
  input wire [DW-1:0] wd_i,
  input wire re_i,
  input wire [AW-1:0] ra_i,
  output reg [DW-1:0] rq_o
);

  // Storage cells, no reset as in a real array
  reg [DW-1:0] cells [0:(1<<AW)-1];

  // Write and registered read
  always @(posedge clk_i)
  begin
    if (we_i)
    begin
      cells[wa_i] <= wd_i;
    end
    if (re_i)
    begin
      rq_o <= cells[ra_i];
    end
  end

endmodule

// ---- hdl/sea_core.v ----
`timescale 1ns/1ps
`include "sea_defs.vh"

module sea_core #(
  parameter integer PROG_CYCLES = `SEA_PROG_CYCLES
)(
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o
);

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam [17:0] PROG_LAST = PROG_CYCLES[17:0] - 18'h0_0001;
  localparam [17:0] PROG_HALF = {1'b0, PROG_CYCLES[17:1]};
  localparam [17:0] FILL_SPAN = 18'h0_0040;

  // One-hot protocol states
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_RX = 6'h02;
  localparam [5:0] S_ACK = 6'h04;
  localparam [5:0] S_TX = 6'h08;
  localparam [5:0] S_MACK = 6'h10;
  localparam [5:0] S_PROG = 6'h20;

  // ----------------------------------------
  // Byte order helper
  // ----------------------------------------
  // Picks the high half for byte slot idx under the current order
  function pick_high;
    input idx;
    input low_first;
    begin
      pick_high = idx ^ ~low_first;
    end
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg scl_m, scl_s, scl_p; // Clock pin synchroniser and history
  reg sda_m, sda_s, sda_p; // Data pin synchroniser and history
  reg [5:0] state; // Protocol state
  reg [7:0] shreg; // Shift register for both directions
  reg [3:0] bitcnt; // Bits moved in current byte
  reg is_ctrl; // Next received byte is a control byte
  reg [4:0] row; // Current row address
  reg low_first; // Byte order and step direction
  reg dir; // Direction from control byte
  reg page; // Selected page
  reg [1:0] wcnt; // Data bytes taken in this write
  reg bidx; // Byte slot within buffer during reads
  reg macked; // Master acknowledged, next byte pending
  reg wpend; // Buffer holds data awaiting programming
  reg fpend; // Whole-array fill pending
  reg fill_one; // Fill value
  reg spec; // Last control byte was a special command
  reg [15:0] buffer; // Word buffer
  reg rd_req; // Read strobe into the array
  reg ld_d; // Array read data is valid
  reg [17:0] pcnt; // Programming cycle timer
  reg ctrl_en; // Software enable of the slave
  wire [15:0] mem_q; // Array read data
  wire scl_rise; // Clock edge events
  wire scl_fall;
  wire start_ev; // Bus conditions
  wire stop_ev;
  wire in_prog;
  wire erase_win;
  wire write_win;
  wire mem_we;
  wire [5:0] mem_wa;
  wire [15:0] mem_wd;
  wire [7:0] tx_byte;

  // ----------------------------------------
  // Pin synchronisers and edge finders
  // ----------------------------------------
  // First stage feeds only the second stage
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
    end
    else
    begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_ev = scl_s & scl_p & ~sda_p & sda_s;

  // ----------------------------------------
  // Array write path
  // ----------------------------------------
  assign in_prog = state[5];
  assign erase_win = fpend ? (pcnt < FILL_SPAN) : (pcnt == 18'h0_0000);
  assign write_win = fpend ? ((pcnt >= PROG_HALF) && (pcnt < PROG_HALF + FILL_SPAN)) : (pcnt == PROG_HALF);
  assign mem_we = in_prog & (erase_win | write_win);
  // fill walks every word of both pages
  assign mem_wa = fpend ? (write_win ? (pcnt[5:0] - PROG_HALF[5:0]) : pcnt[5:0]) : {page, row};
  assign mem_wd = erase_win ? 16'h0000 : (fpend ? {16{fill_one}} : buffer);

  // byte chosen by slot and order
  assign tx_byte = pick_high(bidx, low_first) ? buffer[15:8] : buffer[7:0];

  sea_mem #(
    .AW(`SEA_ADDR_W),
    .DW(`SEA_WORD_W)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .wa_i(mem_wa),
    .wd_i(mem_wd),
    .re_i(rd_req),
    .ra_i({page, row}),
    .rq_o(mem_q)
  );

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  // Bus conditions are handled last so they override the byte logic
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= S_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      is_ctrl <= 1'b0;
      row <= 5'h00;
      low_first <= 1'b0;
      dir <= 1'b0;
      page <= `SEA_PAGE_RST;
      wcnt <= 2'h0;
      bidx <= 1'b0;
      macked <= 1'b0;
      wpend <= 1'b0;
      fpend <= 1'b0;
      fill_one <= 1'b0;
      spec <= 1'b0;
      buffer <= 16'h0000;
      rd_req <= 1'b0;
      ld_d <= 1'b0;
      pcnt <= 18'h0_0000;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end
    else
    begin
      rd_req <= 1'b0;
      ld_d <= rd_req;
      if (ld_d)
      begin
        buffer <= mem_q;
      end
      case (state)
        S_IDLE:
        begin
          sda_oe_o <= 1'b0;
        end
        S_RX:
        begin
          // Sample data on rising clock
          if (scl_rise && bitcnt != 4'h8)
          begin
            shreg <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end
          else if (scl_fall && bitcnt == 4'h8)
          begin
            bitcnt <= 4'h0;
            if (is_ctrl)
            begin
              // Control byte: acknowledged in every case
              sda_oe_o <= 1'b1;
              state <= S_ACK;
              spec <= 1'b1;
              case (shreg)
                `SEA_CMD_PAGE1: page <= 1'b1;
                `SEA_CMD_PAGE0: page <= 1'b0;
                `SEA_CMD_FILL0:
                begin
                  fpend <= 1'b1;
                  fill_one <= 1'b0;
                end
                `SEA_CMD_FILL1:
                begin
                  fpend <= 1'b1;
                  fill_one <= 1'b1;
                end
                `SEA_CMD_INIT: spec <= 1'b1;
                default:
                begin
                  row <= shreg[`SEA_CB_ROW_MSB:`SEA_CB_ROW_LSB];
                  low_first <= (shreg[`SEA_CB_MODE_MSB:`SEA_CB_MODE_LSB] == `SEA_MODE_LOW_INC);
                  dir <= shreg[`SEA_CB_DIR_BIT];
                  spec <= 1'b0;
                  rd_req <= 1'b1;
                end
              endcase
            end
            else if (wcnt != 2'h2)
            begin
              if (pick_high(wcnt[0], low_first))
              begin
                buffer[15:8] <= shreg;
              end
              else
              begin
                buffer[7:0] <= shreg;
              end
              wcnt <= wcnt + 2'h1;
              wpend <= 1'b1;
              sda_oe_o <= 1'b1;
              state <= S_ACK;
            end
            else
            begin
              // Third data byte is refused, no acknowledge
              state <= S_IDLE;
            end
          end
        end
        S_ACK:
        begin
          // Acknowledge held until the next falling clock edge
          if (scl_fall)
          begin
            bitcnt <= 4'h0;
            if (spec)
            begin
              sda_oe_o <= 1'b0;
              state <= S_IDLE;
            end
            else if (dir)
            begin
              // first byte leaves right after acknowledge
              shreg <= tx_byte;
              sda_oe_o <= ~tx_byte[7];
              state <= S_TX;
            end
            else
            begin
              sda_oe_o <= 1'b0;
              is_ctrl <= 1'b0;
              state <= S_RX;
            end
          end
        end
        S_TX:
        begin
          // Next bit is driven on falling clock
          if (scl_fall)
          begin
            if (bitcnt == 4'h7)
            begin
              sda_oe_o <= 1'b0;
              state <= S_MACK;
            end
            else
            begin
              sda_oe_o <= ~shreg[6];
              shreg <= {shreg[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        S_MACK:
        begin
          if (scl_rise)
          begin
            if (sda_s)
            begin
              state <= S_IDLE;
            end
            else
            begin
              macked <= 1'b1;
              bidx <= ~bidx;
              // second byte read, step and reload
              if (bidx)
              begin
                row <= low_first ? row + 5'h01 : row - 5'h01;
                rd_req <= 1'b1;
              end
            end
          end
          else if (scl_fall && macked)
          begin
            macked <= 1'b0;
            bitcnt <= 4'h0;
            shreg <= tx_byte;
            sda_oe_o <= ~tx_byte[7];
            state <= S_TX;
          end
        end
        S_PROG:
        begin
          sda_oe_o <= 1'b0;
          pcnt <= pcnt + 18'h0_0001;
          if (pcnt == PROG_LAST)
          begin
            wpend <= 1'b0;
            fpend <= 1'b0;
            state <= S_IDLE;
          end
        end
        default:
        begin
          state <= S_IDLE;
          sda_oe_o <= 1'b0;
        end
      endcase
      // Bus conditions, not seen while busy
      if (!in_prog && stop_ev)
      begin
        sda_oe_o <= 1'b0;
        macked <= 1'b0;
        if (wpend || fpend)
        begin
          pcnt <= 18'h0_0000;
          state <= S_PROG;
        end
        else
        begin
          state <= S_IDLE;
        end
      end
      else if (!in_prog && start_ev && ctrl_en)
      begin
        state <= S_RX;
        is_ctrl <= 1'b1;
        bitcnt <= 4'h0;
        wcnt <= 2'h0;
        bidx <= 1'b0;
        macked <= 1'b0;
        wpend <= 1'b0;
        fpend <= 1'b0;
        spec <= 1'b0;
        sda_oe_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Wishbone register slave
  // ----------------------------------------
  // One wait state keeps read data registered
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_en <= `SEA_CTRL_EN_RST;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o)
      begin
        // Enable gates acceptance of new START conditions
        if (wb_we_i && wb_sel_i[0] && wb_adr_i == `SEA_ADR_CTRL)
        begin
          ctrl_en <= wb_dat_i[`SEA_CTRL_EN_BIT];
        end
        // Unmapped addresses read as zero
        if (wb_adr_i == `SEA_ADR_CTRL)
        begin
          wb_dat_o <= {31'h0000_0000, ctrl_en};
        end
        else if (wb_adr_i == `SEA_ADR_STAT)
        begin
          wb_dat_o <= {23'h00_0000, row, 2'h0, page, in_prog};
        end
        else
        begin
          wb_dat_o <= 32'h0000_0000;
        end
      end
    end
  end

endmodule

// ---- tb/sea_chk.sv ----
`timescale 1ns/1ps
module sea_chk (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Cycles the data wire has been pulled low without a break
  reg [7:0] oe_run;
  always @(posedge clk_i)
  begin
    if (rst_i || !sda_oe_o)
      oe_run <= 8'h00;
    else if (oe_run != 8'hff)
      oe_run <= oe_run + 8'h01;
  end
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_wait;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("ack not one cycle after request");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_unmapped;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i != 8'h00 && wb_adr_i != 8'h04
      |=> wb_dat_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_dat_hold;
    !wb_cyc_i |=> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved while idle");
  property p_drive_low;
    sda_o == 1'b0;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("data wire driven high");
  property p_oe_scl_low;
    $changed(sda_oe_o) |-> !scl_i;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data changed with clock high");
  property p_oe_rise;
    $rose(sda_oe_o) |-> !$past(scl_i) && !$past(scl_i, 2);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive started too near clock edge");
  property p_oe_run;
    oe_run < 8'h50;
  endproperty
  a_oe_run: assert property (p_oe_run) else $error("data wire held low too long");
endmodule
bind sea_core sea_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .scl_i, .sda_i, .sda_o, .sda_oe_o);

// ---- tb/sea_mst.sv ----
`timescale 1ns/1ps
module sea_mst (
  input wire clk_i,
  input wire sda_i,
  output reg scl_o,
  output reg sda_low_o
);
  // Idle: clock stands high, data left to the pull-up
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Set both lines after an edge, hold for n cycles
  task sig(input c, input d, input integer n);
  begin
    @(posedge clk_i);
    scl_o <= c;
    sda_low_o <= !d;
    repeat (n - 1) @(posedge clk_i);
  end
  endtask
  task bit_io(input b, output r);
  begin
    sig(1'b0, !sda_low_o, 1);
    sig(1'b0, b, 3);
    sig(1'b1, b, 4);
    r = sda_i;
  end
  endtask
  task wbyte(input [7:0] v, output ack);
    integer i;
    reg r;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = !r;
  end
  endtask
  task rbyte(input mack, output [7:0] v);
    integer i;
    reg r;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bit_io(1'b1, v[i]);
    bit_io(!mack, r);
  end
  endtask
  task start;
  begin
    sig(1'b0, !sda_low_o, 4);
    sig(1'b0, 1'b1, 4);
    sig(1'b1, 1'b1, 4);
    sig(1'b1, 1'b0, 4);
  end
  endtask
  task stop;
  begin
    sig(1'b0, !sda_low_o, 4);
    sig(1'b0, 1'b0, 4);
    sig(1'b1, 1'b0, 4);
    sig(1'b1, 1'b1, 4);
  end
  endtask
endmodule

// ---- tb/serial_eeprom_access_bench.sv ----
`timescale 1ns/1ps
module serial_eeprom_access_bench;
  reg clk, rst, cyc, stb, we, a;
  reg [7:0] adr, b;
  reg [3:0] sel;
  reg [31:0] dat, st;
  reg [76:0] rows [0:5];
  wire [31:0] rdat;
  wire ack, scl, m_low, sda_o, oe;
  // Pull-up wire: low if either side pulls
  wire sda = (oe ? sda_o : 1'b1) & !m_low;
  integer mismatches = 0, comparisons = 0, cycles = 0, i;
  sea_core #(.PROG_CYCLES(256)) DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(oe));
  sea_mst M (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  // Hang guard, well above the whole run
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
      mismatches = mismatches + 1;
      finish_test;
    end
  end
  task finish_test;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task chk(input string name, input [31:0] e, input [31:0] g);
  begin
    comparisons = comparisons + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %0s expected %h seen %h", name, e, g);
    end
  end
  endtask
  // One classic cycle, held until ack is sampled
  // No local limit: only the hang guard may end a stuck wait
  task wb(input w, input [7:0] ad, input [3:0] s, input [31:0] d, output [31:0] q);
  begin
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, ad, s, d};
    @(posedge clk);
    while (ack !== 1'b1)
    begin
      @(posedge clk);
    end
    q = rdat;
    {cyc, stb} <= 2'b00;
  end
  endtask
  // Control write alone until acked
  task wait_ready;
    integer t;
  begin
    a = 1'b0;
    for (t = 0; t < 20 && !a; t = t + 1)
    begin
      M.start;
      M.wbyte(8'h04, a);
      M.stop;
    end
    chk("ready", 1, a);
  end
  endtask
  // Page commands and bare control bytes start no programming cycle
  task wr(input [7:0] c, input [15:0] d, input integer n);
    integer k;
    reg bsy;
  begin
    bsy = (n > 0) || (c == 8'h07) || (c == 8'h0f);
    M.start;
    M.wbyte(c, a);
    chk("ctl ack", 1, a);
    for (k = 0; k < n; k = k + 1)
    begin
      M.wbyte(d[15 - 8 * k -: 8], a);
      chk("data ack", 1, a);
    end
    M.stop;
    wb(1'b0, 8'h04, 4'hf, 32'h0000_0000, st);
    chk("busy", bsy, st[0]);
    M.start;
    M.wbyte(c, a);
    chk("busy nack", !bsy, a);
    M.stop;
    wait_ready;
  end
  endtask
  task rd(input [7:0] c, input [31:0] e, input integer n);
    integer k;
  begin
    M.start;
    M.wbyte(c, a);
    chk("read ack", 1, a);
    for (k = 0; k < n; k = k + 1)
    begin
      M.rbyte(k < n - 1, b);
      chk("read byte", e[8 * (n - 1 - k) +: 8], b);
    end
    M.sig(1'b0, 1'b1, 8);
    chk("released", 1, sda);
    M.stop;
  end
  endtask
  initial
  begin
    {rst, cyc, stb, we, adr, sel, dat} = {4'h8, 8'h00, 4'h0, 32'h0000_0000};
    rows[0] = {1'b0, 8'h00, 4'hf, 32'h0000_0000, 32'h0000_0001};
    rows[1] = {1'b0, 8'h04, 4'hf, 32'h0000_0000, 32'h0000_0000};
    rows[2] = {1'b1, 8'h08, 4'hf, 32'hffff_ffff, 32'h0000_0000};
    rows[3] = {1'b0, 8'h08, 4'hf, 32'h0000_0000, 32'h0000_0000};
    rows[4] = {1'b1, 8'h00, 4'he, 32'h0000_0000, 32'h0000_0000};
    rows[5] = {1'b0, 8'h00, 4'hf, 32'h0000_0000, 32'h0000_0001};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (i = 0; i < 6; i = i + 1)
    begin
      wb(rows[i][76], rows[i][75:68], rows[i][67:64], rows[i][63:32], st);
      if (!rows[i][76])
        chk("wb read", rows[i][31:0], st);
    end
    wr(8'h07, 16'h0000, 0);
    wr(8'hfa, 16'h3412, 2);
    wr(8'h04, 16'hab00, 1);
    rd(8'hfb, 32'h3412_00ab, 4);
    rd(8'h05, 32'hab00_1234, 4);
    wr(8'h01, 16'h0000, 0);
    wb(1'b0, 8'h04, 4'hf, 32'h0000_0000, st);
    chk("page", 1, st[1]);
    rd(8'hfb, 32'h0000_0000, 1);
    wr(8'h09, 16'h0000, 0);
    rd(8'hfb, 32'h0000_0034, 1);
    wr(8'h0f, 16'h0000, 0);
    rd(8'h3d, 32'h0000_ffff, 2);
    wb(1'b0, 8'h04, 4'hf, 32'h0000_0000, st);
    chk("status", 32'h0000_0070, st);
    M.start;
    M.wbyte(8'h0c, a);
    M.wbyte(8'h55, a);
    M.wbyte(8'h66, a);
    M.wbyte(8'h77, a);
    chk("third nack", 0, a);
    M.stop;
    wait_ready;
    rd(8'h0d, 32'h0000_5566, 2);
    // Slave disabled: a new START must go unanswered
    wb(1'b1, 8'h00, 4'hf, 32'h0000_0000, st);
    M.start;
    M.wbyte(8'h04, a);
    M.stop;
    chk("disabled nack", 0, a);
    finish_test;
  end
endmodule
